// [design/ect_pkg.sv]
package ect_pkg;
    localparam int unsigned CNT_W        = 16;
    localparam logic [1:0]  MODE_EVENT   = 2'b01;
    localparam logic [15:0] CNT_MAX      = 16'hFFFF;
    localparam logic [15:0] CNT_MIN      = 16'h0000;
    localparam logic [15:0] CNT_RST      = 16'h0000;
    localparam int unsigned SYNC_STAGES  = 2;
    localparam logic [1:0]  CHAN_PLAIN   = 2'b00;
    localparam logic [1:0]  CHAN_DUAL    = 2'b01;
    localparam logic [1:0]  CHAN_QUAD    = 2'b10;
    typedef enum logic [1:0] {
        ECT_IDLE  = 2'b00,
        ECT_COUNT = 2'b01
    } ect_state_e;
endpackage

// [design/ect_edge.sv]
`timescale 1ns/1ps
// Two-stage synchroniser with edge detection on the second stage
module ect_edge (
    input  wire logic CLK,
    input  wire logic RST_B,
    input  wire logic CE,
    input  wire logic PIN,
    output logic      LEVEL,
    output logic      RISE,
    output logic      FALL
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else if (CE) begin
            meta_ff <= PIN;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign LEVEL = sync_ff;
    assign RISE  = CE & sync_ff & ~last_ff;
    assign FALL  = CE & ~sync_ff & last_ff;
endmodule // ect_edge

// [design/ect_top.sv]
`timescale 1ns/1ps
// Function
// - Event counting runs only when mode bits are 01; bit 5 kept zero.
// - Reload from reload register when leaving FFFF up or 0000 down.
// - Write while stopped loads counter and reload register together.
// - Input edges reach the counter only while count start is one.
// - Polarity zero counts falling edges, one counts rising edges.
// - Direction source zero uses up-down flag, one uses output pin level.
// - Up-down flag zero counts down, one counts up.
// - Pin low counts down, pin high counts up.
// - Direction change applies at next effective count edge.
// - Every underflow or overflow sets the interrupt request bit.
// - Request bit holds until accepted or cleared by software.
// - Timer read returns live counter; reload register is unreadable.
// - Write while counting updates only reload register, except at a wrap, where the counter also loads the written value.
// - Read at reload gives FFFF underflow, 0000 overflow; before start gives written value.
// - Pulse output selected toggles output pin each underflow or overflow.
// - Pulse output forces pin to output regardless of port direction.
// - Pulse output held low while count start is zero.
// - Pin-direction, pulse output and two-phase are mutually exclusive; here pin-direction or two-phase overrides pulse output.
// - Dual channels: rise on input increments, fall decrements, after phase pin high.
// - Quad channel: input leading phase decrements on every edge of both pins.
// - Quad channel: phase leading input increments on every edge of both pins.
module ect_top #(
    parameter logic [1:0] CHAN_KIND = ect_pkg::CHAN_QUAD
) (
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        CE,
    input  wire logic [1:0]  MODE_SEL,
    input  wire logic        COUNT_START,
    input  wire logic        COUNT_POL,
    input  wire logic        DIR_SRC,
    input  wire logic        UP_DOWN_FLAG,
    input  wire logic        PULSE_SEL,
    input  wire logic        TWO_PHASE_SEL,
    input  wire logic        PORT_DIR_OUT,
    input  wire logic        PORT_DATA,
    input  wire logic        COUNT_INPUT_PIN,
    input  wire logic        CHANNEL_OUTPUT_PIN_IN,
    output logic             CHANNEL_OUTPUT_PIN_OUT,
    output logic             CHANNEL_OUTPUT_PIN_OE_B,
    input  wire logic        WR_EN,
    input  wire logic [15:0] WR_DATA,
    output logic [15:0]      RD_DATA,
    output logic             IRQ,
    input  wire logic        IRQ_ACK,
    input  wire logic        IRQ_CLR
);
    logic                 in_lvl;
    logic                 in_rise;
    logic                 in_fall;
    logic                 ph_lvl;
    logic                 ph_rise;
    logic                 ph_fall;
    logic [15:0]          cnt_ff;
    logic [15:0]          reload_ff;
    logic [15:0]          rd_ff;
    logic                 irq_ff;
    logic                 pulse_ff;
    logic                 phase_armed_ff;
    ect_pkg::ect_state_e  state_ff;
    ect_pkg::ect_state_e  nxt_state;
    logic                 active;
    logic                 step;
    logic                 up;
    logic                 wrap;
    logic                 two_phase;

    ect_edge u_in (
        .CLK   (CLK),
        .RST_B (RST_B),
        .CE    (CE),
        .PIN   (COUNT_INPUT_PIN),
        .LEVEL (in_lvl),
        .RISE  (in_rise),
        .FALL  (in_fall)
    );

    ect_edge u_ph (
        .CLK   (CLK),
        .RST_B (RST_B),
        .CE    (CE),
        .PIN   (CHANNEL_OUTPUT_PIN_IN),
        .LEVEL (ph_lvl),
        .RISE  (ph_rise),
        .FALL  (ph_fall)
    );

    function automatic logic [15:0] wrap_val(input logic u);
        wrap_val = u ? ect_pkg::CNT_MAX : ect_pkg::CNT_MIN;
    endfunction

    assign two_phase = TWO_PHASE_SEL && (CHAN_KIND != ect_pkg::CHAN_PLAIN);

    always_comb begin
        nxt_state = ect_pkg::ECT_IDLE;
        case (state_ff)
            ect_pkg::ECT_IDLE:
                if (MODE_SEL == ect_pkg::MODE_EVENT && COUNT_START) begin
                    nxt_state = ect_pkg::ECT_COUNT;
                end
            ect_pkg::ECT_COUNT:
                if (MODE_SEL == ect_pkg::MODE_EVENT && COUNT_START) begin
                    nxt_state = ect_pkg::ECT_COUNT;
                end
            default: nxt_state = ect_pkg::ECT_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            state_ff <= ect_pkg::ECT_IDLE;
        end else if (CE) begin
            state_ff <= nxt_state;
        end
    end

    assign active = (state_ff == ect_pkg::ECT_COUNT) && COUNT_START
                    && (MODE_SEL == ect_pkg::MODE_EVENT);

    // Arming tracked even when stopped so the first edge is judged right
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            phase_armed_ff <= 1'b0;
        end else if (CE) begin
            if (ph_rise) begin
                phase_armed_ff <= 1'b1;
            end else if (ph_fall) begin
                phase_armed_ff <= 1'b0;
            end
        end
    end

    // Step and direction per sampled edge; direction is read at the edge itself
    always_comb begin
        step = 1'b0;
        up   = 1'b0;
        if (two_phase) begin
            if (CHAN_KIND == ect_pkg::CHAN_QUAD) begin
                step = in_rise | in_fall | ph_rise | ph_fall;
                up   = (in_rise & ph_lvl) | (in_fall & ~ph_lvl)
                     | (ph_rise & ~in_lvl) | (ph_fall & in_lvl);
            end else begin
                step = phase_armed_ff & (in_rise | in_fall);
                up   = in_rise;
            end
        end else begin
            step = COUNT_POL ? in_rise : in_fall;
            up   = DIR_SRC ? ph_lvl : UP_DOWN_FLAG;
        end
    end

    assign wrap = active && step &&
                  (cnt_ff == wrap_val(up));

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            cnt_ff    <= ect_pkg::CNT_RST;
            reload_ff <= ect_pkg::CNT_RST;
        end else if (CE) begin
            if (WR_EN) begin
                reload_ff <= WR_DATA;
            end
            if (WR_EN && !active) begin
                cnt_ff <= WR_DATA;
            end else if (wrap) begin
                cnt_ff <= WR_EN ? WR_DATA : reload_ff;
            end else if (active && step) begin
                cnt_ff <= up ? cnt_ff + 16'h0001 : cnt_ff - 16'h0001;
            end
        end
    end

    // read path: wrap value shown in the reload cycle
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rd_ff <= ect_pkg::CNT_RST;
        end else if (CE) begin
            if (wrap) begin
                rd_ff <= up ? ect_pkg::CNT_MIN : ect_pkg::CNT_MAX;
            end else if (WR_EN && !active) begin
                rd_ff <= WR_DATA;
            end else begin
                rd_ff <= cnt_ff;
            end
        end
    end
    assign RD_DATA = rd_ff;

    // request bit, set wins over clear
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            irq_ff <= 1'b0;
        end else if (CE) begin
            if (wrap) begin
                irq_ff <= 1'b1;
            end else if (IRQ_ACK || IRQ_CLR) begin
                irq_ff <= 1'b0;
            end
        end
    end
    assign IRQ = irq_ff;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pulse_ff <= 1'b0;
        end else if (CE) begin
            if (!COUNT_START) begin
                pulse_ff <= 1'b0;
            end else if (wrap && PULSE_SEL) begin
                pulse_ff <= ~pulse_ff;
            end
        end
    end

    // pin ownership; pulse output wins unless DIR_SRC or two-phase is set, else port logic
    always_comb begin
        if (PULSE_SEL && !DIR_SRC && !two_phase) begin
            CHANNEL_OUTPUT_PIN_OUT  = pulse_ff;
            CHANNEL_OUTPUT_PIN_OE_B = 1'b0;
        end else begin
            CHANNEL_OUTPUT_PIN_OUT  = PORT_DATA;
            CHANNEL_OUTPUT_PIN_OE_B = ~PORT_DIR_OUT;
        end
    end

    a_irq_on_wrap: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && wrap |=> irq_ff)
        else $error("request bit not set after wrap");

    a_irq_holds: assert property (@(posedge CLK) disable iff (!RST_B)
        irq_ff && CE && !IRQ_ACK && !IRQ_CLR |=> irq_ff)
        else $error("request bit dropped without clear");

    a_irq_clear: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && !wrap && (IRQ_ACK || IRQ_CLR) |=> !irq_ff)
        else $error("request bit not cleared");

    a_reload_load: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && wrap && !WR_EN |=> cnt_ff == $past(reload_ff))
        else $error("counter not reloaded on wrap");

    a_mode_gate: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && MODE_SEL != ect_pkg::MODE_EVENT && !WR_EN |=> $stable(cnt_ff))
        else $error("counter moved outside event mode");

    a_count_step: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && active && step && !wrap |=>
        cnt_ff == ($past(up) ? $past(cnt_ff) + 16'h0001 : $past(cnt_ff) - 16'h0001))
        else $error("counter step wrong");

    a_stop_holds: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && !COUNT_START && !WR_EN |=> $stable(cnt_ff))
        else $error("counter moved while stopped");

    a_pulse_low: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && !COUNT_START |=> !pulse_ff)
        else $error("pulse output high while stopped");

    a_pulse_toggle: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && COUNT_START && PULSE_SEL && wrap |=> pulse_ff != $past(pulse_ff))
        else $error("pulse output did not toggle");

    a_write_load: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && WR_EN && !active |=> cnt_ff == $past(WR_DATA) && reload_ff == $past(WR_DATA))
        else $error("stopped write did not load both");

    a_write_run: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && WR_EN && active && !step |=> $stable(cnt_ff))
        else $error("running write changed counter");

    a_read_live: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && !wrap && !(WR_EN && !active) |=> RD_DATA == $past(cnt_ff))
        else $error("read value not live counter");

    a_read_wrap: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && wrap && !up |=> RD_DATA == ect_pkg::CNT_MAX)
        else $error("read at underflow not all ones");

    a_read_over: assert property (@(posedge CLK) disable iff (!RST_B)
        CE && wrap && up |=> RD_DATA == ect_pkg::CNT_MIN)
        else $error("read at overflow not zero");

    a_dual_gate: assert property (@(posedge CLK) disable iff (!RST_B)
        two_phase && CHAN_KIND == ect_pkg::CHAN_DUAL && !phase_armed_ff |-> !step)
        else $error("dual channel counted while unarmed");

    a_quad_up: assert property (@(posedge CLK) disable iff (!RST_B)
        two_phase && CHAN_KIND == ect_pkg::CHAN_QUAD && in_rise && ph_lvl
        && !ph_rise && !ph_fall |-> up)
        else $error("quad rise after phase high not counted up");

    a_quad_down: assert property (@(posedge CLK) disable iff (!RST_B)
        two_phase && CHAN_KIND == ect_pkg::CHAN_QUAD && ph_fall && !in_lvl
        && !in_rise && !in_fall |-> !up)
        else $error("quad phase fall after input low not counted down");

    a_pin_forced: assert property (@(posedge CLK) disable iff (!RST_B)
        PULSE_SEL && !DIR_SRC && !two_phase |-> !CHANNEL_OUTPUT_PIN_OE_B)
        else $error("pulse pin not driven");

    a_pin_port: assert property (@(posedge CLK) disable iff (!RST_B)
        !(PULSE_SEL && !DIR_SRC && !two_phase) |-> CHANNEL_OUTPUT_PIN_OE_B == !PORT_DIR_OUT)
        else $error("port direction not honoured");

    c_underflow: cover property (@(posedge CLK) disable iff (!RST_B) wrap && !up);
    c_overflow: cover property (@(posedge CLK) disable iff (!RST_B) wrap && up);
    c_quad_step: cover property (@(posedge CLK) disable iff (!RST_B) two_phase && step);
    c_dual_step: cover property (@(posedge CLK) disable iff (!RST_B)
        two_phase && CHAN_KIND == ect_pkg::CHAN_DUAL && step);
    c_pulse_flip: cover property (@(posedge CLK) disable iff (!RST_B) wrap && PULSE_SEL);
endmodule // ect_top

// [verif/ect_src.sv]
`timescale 1ns/1ps
// Pulse source for the count and phase pins.
// The bench spaces its toggles so each level lasts at least 8 clocks.
module ect_src (
    input  wire logic CLK,
    input  wire logic TOG_A,
    input  wire logic TOG_B,
    output logic      A,
    output logic      B
);
    initial begin
        A = 1'b0;
        B = 1'b0;
    end
    always @(posedge CLK) begin
        if (TOG_A) A <= ~A;
        if (TOG_B) B <= ~B;
    end
endmodule // ect_src

// [verif/ect_top_bench.sv]
`timescale 1ns/1ps
module ect_top_bench;
    logic        clk, rst_b, start, pol, dsrc, flag, psel, tp, wr_en, irq_ack, irq_clr;
    logic        tog_a, tog_b, pout, oe_b, irq, pout2, oe2, irq2, arm, pexp, ak, pdat;
    logic [1:0]  mode;
    logic [15:0] wr_data, rd, rd2, cnt, cnt2, rl;
    logic [31:0] r;
    wire         a, b, pin, pin2;
    int          seed, fail_count, checked;

    ect_src i_src (.CLK(clk), .TOG_A(tog_a), .TOG_B(tog_b), .A(a), .B(b));
    assign pin  = oe_b ? b : pout;
    assign pin2 = oe2 ? b : pout2;
    ect_top i_dut (.CLK(clk), .RST_B(rst_b), .CE(1'b1), .MODE_SEL(mode), .COUNT_START(start),
        .COUNT_POL(pol), .DIR_SRC(dsrc), .UP_DOWN_FLAG(flag), .PULSE_SEL(psel),
        .TWO_PHASE_SEL(tp), .PORT_DIR_OUT(1'b0), .PORT_DATA(pdat), .COUNT_INPUT_PIN(a),
        .CHANNEL_OUTPUT_PIN_IN(pin), .CHANNEL_OUTPUT_PIN_OUT(pout),
        .CHANNEL_OUTPUT_PIN_OE_B(oe_b), .WR_EN(wr_en), .WR_DATA(wr_data), .RD_DATA(rd),
        .IRQ(irq), .IRQ_ACK(irq_ack), .IRQ_CLR(irq_clr));
    ect_top #(.CHAN_KIND(ect_pkg::CHAN_DUAL)) i_dual (.CLK(clk), .RST_B(rst_b), .CE(1'b1),
        .MODE_SEL(mode), .COUNT_START(start), .COUNT_POL(pol), .DIR_SRC(dsrc),
        .UP_DOWN_FLAG(flag), .PULSE_SEL(psel), .TWO_PHASE_SEL(tp), .PORT_DIR_OUT(1'b0),
        .PORT_DATA(pdat), .COUNT_INPUT_PIN(a), .CHANNEL_OUTPUT_PIN_IN(pin2),
        .CHANNEL_OUTPUT_PIN_OUT(pout2), .CHANNEL_OUTPUT_PIN_OE_B(oe2), .WR_EN(wr_en),
        .WR_DATA(wr_data), .RD_DATA(rd2), .IRQ(irq2), .IRQ_ACK(irq_ack), .IRQ_CLR(irq_clr));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Wrap reloads from the reload value, not from the edge value
    function automatic logic [15:0] nx(input logic [15:0] c, input int d, output logic w);
        w = (d > 0 && c == 16'hFFFF) || (d < 0 && c == 16'h0000);
        return w ? rl : c + d[15:0];
    endfunction

    task automatic wr(input logic [15:0] v);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_data <= v;
        @(posedge clk);
        wr_en <= 1'b0;
        tk(3);
        rl = v;
        if (!start) {cnt, cnt2} = {v, v};
        chk(rd, cnt);
    endtask

    task automatic go(input logic s);
        @(posedge clk);
        start <= s;
        tk(3);
        if (!s) pexp = 1'b0;
        if (psel) chk(pout, pexp);
    endtask

    // One toggle of pin A (w=0) or B (w=1), then compare both channels
    task automatic ev(input logic w);
        logic        na, nb, hit, h2, seen;
        int          d, d2;
        logic [15:0] wv;
        // Settings given on this edge must settle before they are read
        #1;
        na = w ? a : ~a;
        nb = w ? ~b : b;
        d = 0;
        d2 = 0;
        if (start && mode == ect_pkg::MODE_EVENT) begin
            if (tp) begin
                d = (w ? na != nb : na == nb) ? 1 : -1;
                if (w) arm = nb;
                else if (arm) d2 = na ? 1 : -1;
            end else if (!w && na == pol) begin
                d = (dsrc ? nb : flag) ? 1 : -1;
                d2 = d;
            end
        end
        wv = (d > 0) ? 16'h0000 : 16'hFFFF;
        cnt = nx(cnt, d, hit);
        cnt2 = nx(cnt2, d2, h2);
        if (hit && psel) pexp = ~pexp;
        seen = 1'b0;
        @(posedge clk);
        if (w) tog_b <= 1'b1;
        else tog_a <= 1'b1;
        @(posedge clk);
        {tog_a, tog_b} <= 2'b00;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (rd === wv) seen = 1'b1;
        end
        chk(rd, cnt);
        chk(rd2, cnt2);
        chk(irq, hit);
        chk(irq2, h2);
        if (hit) chk(seen, 1'b1);
        chk({pout, oe_b}, {psel ? pexp : pdat, ~psel});
        chk({pout2, oe2}, {psel ? pexp : pdat, ~psel});
        if (hit || h2) begin
            @(posedge clk);
            irq_ack <= ak;
            irq_clr <= ~ak;
            ak = ~ak;
            @(posedge clk);
            {irq_ack, irq_clr} <= 2'b00;
            tk(2);
            chk(irq | irq2, 1'b0);
        end
    endtask

    initial begin
        tk(20000);
        fail_count++;
        print_verdict();
    end

    initial begin
        seed = 32'hf35a;
        {rst_b, start, pol, dsrc, flag, psel, tp, wr_en, irq_ack, irq_clr, tog_a, tog_b} = '0;
        pdat = 1'b0;
        mode = ect_pkg::MODE_EVENT;
        wr_data = 16'h0000;
        {cnt, cnt2, rl, arm, pexp, ak} = '0;
        fail_count = 0;
        checked = 0;
        tk(4);
        rst_b <= 1'b1;
        tk(1);
        chk(rd, ect_pkg::CNT_RST);
        chk(irq, 1'b0);
        wr(16'h0001);
        go(1'b1);
        repeat (4) ev(1'b0);
        go(1'b0);
        @(posedge clk);
        {flag, pol, psel} <= 3'b111;
        wr(16'hFFFE);
        go(1'b1);
        wr(16'h1234);
        repeat (6) ev(1'b0);
        go(1'b0);
        @(posedge clk);
        psel <= 1'b0;
        go(1'b1);
        repeat (50) begin
            r = $random(seed);
            @(posedge clk);
            {flag, pol, dsrc} <= r[2:0];
            mode <= (r[6:3] == 4'h0) ? 2'b00 : ect_pkg::MODE_EVENT;
            pdat <= r[17];
            if (r[7]) begin
                go(1'b0);
                wr({{14{r[8]}}, r[10:9]});
                go(1'b1);
            end else if (r[11] && r[6:3] != 4'h0) wr(r[31:16]);
            repeat (r[14:12] + 1) ev(r[16:15] == 2'b00);
        end
        go(1'b0);
        @(posedge clk);
        {mode, tp, pol, dsrc, flag} <= {ect_pkg::MODE_EVENT, 4'b1001};
        if (b) ev(1'b1);
        if (a) ev(1'b0);
        wr(16'h0002);
        go(1'b1);
        arm = 1'b0;
        repeat (3) begin
            ev(1'b0);
            ev(1'b1);
            ev(1'b0);
            ev(1'b1);
        end
        repeat (3) begin
            ev(1'b1);
            ev(1'b0);
            ev(1'b1);
            ev(1'b0);
        end
        print_verdict();
    end
endmodule // ect_top_bench
